// File: verilog/audio_dac_mode_register_bank.sv
// mode-control register bank of a stereo audio converter, reached by serial port
// assumes pins arrive asynchronously; flag inputs come from core_clk logic
// Overview of operation
// - word is op bit, seven-bit index, data
// - read data after bit eight, write after sixteen
// - indices sixteen to twenty-one read or write
// - registers twenty-two, twenty-three ignore writes
// - zero pin function bit, default data input
// - bypass mono or stereo bit, default mono
// - rolloff sharp or slow, PCM with internal filter only
// - infinite zero mute enable, default off
// - soft system reset bit, default normal
// - direct stream mode enable, default off
// - internal filter or bypass, default internal
// - mono select and channel choice bits
// - two-bit oversampling rate, default sixty-four
// - de-emphasis rate means FIR performance in stream
// - PCM zero flag enable, default on
// - stream zero flag control, default off
// - zero flags: right bit one, left bit zero
// - device identifier in five low bits
`timescale 1ns/1ps
`default_nettype none
module audio_dac_mode_register_bank
  import dac_mode_pkg::*;
#(
  parameter logic [4:0] DEVICE_ID = 5'h00  // arbitrary value
)(
  input  wire logic       core_clk,                  // core clock
  input  wire logic       rst,                       // async reset, high
  input  wire logic       port_select_n,             // frame select, low active
  input  wire logic       port_bit_clock,            // serial bit clock
  input  wire logic       port_serial_in,            // serial data in
  output logic            port_serial_out,           // serial data out
  input  wire logic       left_zero_detected,        // left channel zero
  input  wire logic       right_zero_detected,       // right channel zero
  output logic [7:0]      left_atten_level,          // left attenuation
  output logic [7:0]      right_atten_level,         // right attenuation
  output logic            atten_load_enable,         // attenuation load
  output logic [2:0]      audio_format_select,       // input data format
  output logic [1:0]      deemph_rate_select,        // de-emphasis rate, pcm
  output logic [1:0]      fir_performance_select,    // analog FIR perf, stream
  output logic            deemph_enable,             // de-emphasis on
  output logic            soft_mute,                 // soft mute on
  output logic            output_phase_invert,       // phase reversal
  output logic [1:0]      atten_rate_select,         // attenuation speed
  output logic            dac_output_disable,        // analog off
  output logic            zero_pin_function,         // stream pins are flags
  output logic            bypass_mono_stereo_select, // bypass stereo
  output logic            rolloff_select,            // slow rolloff
  output logic            infinite_zero_mute_enable, // mute on zero
  output logic            soft_system_reset,         // system reset request
  output logic            stream_mode_enable,        // direct stream mode
  output logic            filter_bypass_enable,      // external filter
  output logic            mono_enable,               // monaural
  output logic            single_channel_source,     // right for mono
  output logic [1:0]      oversample_rate_select,    // modulator rate, pcm
  output logic [1:0]      fir_rate_select,           // FIR rate, stream
  output logic            pcm_zero_flag_enable,      // pcm zero flag on
  output logic [1:0]      stream_zero_flag_control,  // stream zero flags
  output logic            zero_flag_drive_n,         // low while flag pins drive
  output logic            left_zero_flag_out,        // left flag pin value
  output logic            right_zero_flag_out        // right flag pin value
);
  port_link_if link ();

  serial_port_shifter u_shifter (
    .core_clk        (core_clk),
    .rst             (rst),
    .port_select_n   (port_select_n),
    .port_bit_clock  (port_bit_clock),
    .port_serial_in  (port_serial_in),
    .port_serial_out (port_serial_out),
    .link            (link)
  );

  logic [7:0] reg_q [6];
  logic [7:0] reg_d [6];
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] zf_q, zf_d;

  localparam logic [7:0] RST_VAL  [6] = '{RST_LEFT_ATT, RST_RIGHT_ATT, RST_FORMAT,
                                          RST_OUT_FILT, RST_SYS_MODE, RST_ZERO_CTRL};
  localparam logic [7:0] WR_MASK  [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                          MASK_SYS_MODE, MASK_ZERO_CTRL};

  // index to slot; writable bank starts at sixteen
  function automatic logic [2:0] slot(input logic [6:0] idx);
    slot = 3'(idx - IDX_LEFT_ATT);
  endfunction

  function automatic logic in_bank(input logic [6:0] idx, input logic [6:0] top);
    in_bank = idx >= IDX_LEFT_ATT && idx <= top;
  endfunction

  always_comb begin
    for (int i = 0; i < 6; i++) reg_d[i] = reg_q[i];
    zf_d    = {right_zero_detected, left_zero_detected};
    rdata_d = rdata_q;
    // writes only land in 16..21; 22/23 and unmapped indices are dropped
    if (link.wr_stb && in_bank(link.index, IDX_ZERO_CTRL))
      reg_d[slot(link.index)] = link.wdata & WR_MASK[slot(link.index)];
    if (link.rd_stb) begin
      if (in_bank(link.index, IDX_ZERO_CTRL))
        rdata_d = reg_q[slot(link.index)];
      else if (link.index == IDX_ZERO_STAT)
        rdata_d = {6'h00, zf_q};
      else if (link.index == IDX_DEVICE_ID)
        rdata_d = {3'h0, DEVICE_ID};
      else
        rdata_d = 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) reg_q[i] <= RST_VAL[i];
      rdata_q <= 8'h00;
      zf_q    <= 2'h0;
    end else begin
      for (int i = 0; i < 6; i++) reg_q[i] <= reg_d[i];
      rdata_q <= rdata_d;
      zf_q    <= zf_d;
    end
  end

  // read path is combinational so the index captured this cycle answers at once
  always_comb begin
    link.rdata = rdata_q;
    if (link.rd_stb) link.rdata = rdata_d;
  end

  logic [7:0] format_r, filter_r, sys_r, zc_r;
  assign format_r = reg_q[2];
  assign filter_r = reg_q[3];
  assign sys_r    = reg_q[4];
  assign zc_r     = reg_q[5];

  assign left_atten_level          = reg_q[0];
  assign right_atten_level         = reg_q[1];
  assign atten_load_enable         = format_r[POS_ATT_LOAD];
  assign audio_format_select       = format_r[POS_FORMAT +: 3];
  assign deemph_enable             = format_r[POS_DEEMPH_EN];
  assign soft_mute                 = format_r[POS_MUTE];
  // same field, meaning split by mode
  assign deemph_rate_select        = stream_mode_enable ? 2'h0
                                     : format_r[POS_DEEMPH_SEL +: 2];
  assign fir_performance_select    = stream_mode_enable ? format_r[POS_DEEMPH_SEL +: 2]
                                     : 2'h0;
  assign output_phase_invert       = filter_r[POS_PHASE];
  assign atten_rate_select         = filter_r[POS_ATT_RATE +: 2];
  assign dac_output_disable        = filter_r[POS_OUT_OFF];
  assign zero_pin_function         = filter_r[POS_PIN_FUNC];
  assign bypass_mono_stereo_select = filter_bypass_enable & filter_r[POS_BYP_STEREO];
  assign rolloff_select            = ~stream_mode_enable & ~filter_bypass_enable
                                     & filter_r[POS_ROLLOFF];
  assign infinite_zero_mute_enable = ~stream_mode_enable & filter_r[POS_ZERO_MUTE];
  assign soft_system_reset         = sys_r[POS_SOFT_RST];
  assign stream_mode_enable        = sys_r[POS_STREAM];
  assign filter_bypass_enable      = sys_r[POS_BYPASS];
  assign mono_enable               = sys_r[POS_MONO];
  assign single_channel_source     = sys_r[POS_CHANNEL];
  assign oversample_rate_select    = stream_mode_enable ? 2'h0
                                     : sys_r[POS_OVERSAMPLE +: 2];
  assign fir_rate_select           = stream_mode_enable ? sys_r[POS_OVERSAMPLE +: 2]
                                     : 2'h0;
  assign pcm_zero_flag_enable      = ~stream_mode_enable & zc_r[POS_PCM_ZERO];
  assign stream_zero_flag_control  = stream_mode_enable ? zc_r[POS_STRM_ZERO +: 2]
                                     : 2'h0;

  // flags reach pins only when the pins are switched to outputs
  logic flag_en, flag_drive;
  assign flag_en             = pcm_zero_flag_enable | (stream_zero_flag_control != 2'h0);
  assign flag_drive          = zero_pin_function & flag_en;
  assign zero_flag_drive_n   = ~flag_drive;
  assign left_zero_flag_out  = flag_drive & zf_q[0];
  assign right_zero_flag_out = flag_drive & zf_q[1];

  ro_regs_fixed_a: assert property (@(posedge core_clk) disable iff (rst)
    link.wr_stb && link.index >= IDX_ZERO_STAT |=> $stable(reg_q[4]) && $stable(reg_q[5]))
    else $error("read-only write disturbed bank");
  write_lands_a: assert property (@(posedge core_clk) disable iff (rst)
    link.wr_stb && link.index == IDX_OUT_FILT |=> reg_q[3] == $past(link.wdata))
    else $error("write did not land");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_q[4][7] == 1'b0 && reg_q[5][7:3] == 5'h00)
    else $error("reserved bit set");
  status_read_a: assert property (@(posedge core_clk) disable iff (rst)
    link.rd_stb && link.index == IDX_ZERO_STAT |-> link.rdata == {6'h00, zf_q})
    else $error("zero status read wrong");
  id_read_a: assert property (@(posedge core_clk) disable iff (rst)
    link.rd_stb && link.index == IDX_DEVICE_ID |-> link.rdata == {3'h0, DEVICE_ID})
    else $error("device id read wrong");
  mode_split_a: assert property (@(posedge core_clk) disable iff (rst)
    !stream_mode_enable |-> fir_rate_select == 2'h0 && oversample_rate_select == sys_r[1:0])
    else $error("rate field misrouted");
  pins_input_a: assert property (@(posedge core_clk) disable iff (rst)
    !zero_pin_function |-> zero_flag_drive_n)
    else $error("flag pins driven as outputs");
  deemph_split_a: assert property (@(posedge core_clk) disable iff (rst)
    stream_mode_enable |-> deemph_rate_select == 2'h0 && fir_performance_select == format_r[3:2])
    else $error("de-emphasis field misrouted");
endmodule
`default_nettype wire

// File: verilog/dac_mode_pkg.sv
// constants for the audio converter mode-control register bank
// assumes a single 25 MHz core clock; port bit clock arrives asynchronously
package dac_mode_pkg;
  localparam int          WORD_BITS      = 16;
  localparam logic [6:0]  IDX_LEFT_ATT   = 7'h10;
  localparam logic [6:0]  IDX_RIGHT_ATT  = 7'h11;
  localparam logic [6:0]  IDX_FORMAT     = 7'h12;
  localparam logic [6:0]  IDX_OUT_FILT   = 7'h13;
  localparam logic [6:0]  IDX_SYS_MODE   = 7'h14;
  localparam logic [6:0]  IDX_ZERO_CTRL  = 7'h15;
  localparam logic [6:0]  IDX_ZERO_STAT  = 7'h16;
  localparam logic [6:0]  IDX_DEVICE_ID  = 7'h17;
  localparam logic [7:0]  RST_LEFT_ATT   = 8'hFF;
  localparam logic [7:0]  RST_RIGHT_ATT  = 8'hFF;
  localparam logic [7:0]  RST_FORMAT     = 8'h50;
  localparam logic [7:0]  RST_OUT_FILT   = 8'h00;
  localparam logic [7:0]  RST_SYS_MODE   = 8'h00;
  localparam logic [7:0]  RST_ZERO_CTRL  = 8'h01;
  localparam logic [7:0]  MASK_SYS_MODE  = 8'h7F;
  localparam logic [7:0]  MASK_ZERO_CTRL = 8'h07;
  // output_filter_control fields
  localparam int          POS_ZERO_MUTE  = 0;
  localparam int          POS_ROLLOFF    = 1;
  localparam int          POS_BYP_STEREO = 2;
  localparam int          POS_PIN_FUNC   = 3;
  localparam int          POS_OUT_OFF    = 4;
  localparam int          POS_ATT_RATE   = 5;
  localparam int          POS_PHASE      = 7;
  // system_mode_control fields
  localparam int          POS_OVERSAMPLE = 0;
  localparam int          POS_CHANNEL    = 2;
  localparam int          POS_MONO       = 3;
  localparam int          POS_BYPASS     = 4;
  localparam int          POS_STREAM     = 5;
  localparam int          POS_SOFT_RST   = 6;
  // format register fields
  localparam int          POS_MUTE       = 0;
  localparam int          POS_DEEMPH_EN  = 1;
  localparam int          POS_DEEMPH_SEL = 2;
  localparam int          POS_FORMAT     = 4;
  localparam int          POS_ATT_LOAD   = 7;
  // zero control fields
  localparam int          POS_PCM_ZERO   = 0;
  localparam int          POS_STRM_ZERO  = 1;
endpackage

// File: verilog/port_link_if.sv
// carries one decoded control word from the serial shifter to the bank
// assumes both ends sit on core_clk
`timescale 1ns/1ps
`default_nettype none
interface port_link_if;
  logic       wr_stb;    // one-cycle write strobe
  logic       rd_stb;    // one-cycle read request after index
  logic [6:0] index;     // register index
  logic [7:0] wdata;     // write data
  logic [7:0] rdata;     // read data from bank
  modport shifter (output wr_stb, output rd_stb, output index, output wdata, input rdata);
  modport bank    (input wr_stb, input rd_stb, input index, input wdata, output rdata);
endinterface
`default_nettype wire

// File: verilog/serial_port_shifter.sv
// four-wire serial control port: samples pins on core_clk and finds bit clock edges
// assumes the port bit clock is at most core_clk/4 with high and low phases
`timescale 1ns/1ps
`default_nettype none
module serial_port_shifter
  import dac_mode_pkg::*;
(
  input  wire logic       core_clk,         // core clock
  input  wire logic       rst,              // async reset, high
  input  wire logic       port_select_n,    // frame select, low active
  input  wire logic       port_bit_clock,   // serial bit clock
  input  wire logic       port_serial_in,   // serial data in
  output logic            port_serial_out,  // serial data out
  port_link_if.shifter    link              // decoded word to bank
);
  logic [1:0] sel_s_q, sel_s_d, clk_s_q, clk_s_d, din_s_q, din_s_d;
  logic       clk_prev_q, clk_prev_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0] out_q, out_d;
  logic       rd_q, rd_d;
  logic       wr_stb_d, rd_stb_d;
  logic       wr_stb_q, rd_stb_q;
  logic       rise, fall, active;

  // bit 0 of each is the first stage and only feeds bit 1
  assign active = ~sel_s_q[1];
  assign rise   = clk_s_q[1] & ~clk_prev_q & active;
  assign fall   = ~clk_s_q[1] & clk_prev_q & active;

  always_comb begin
    sel_s_d    = {sel_s_q[0], port_select_n};
    clk_s_d    = {clk_s_q[0], port_bit_clock};
    din_s_d    = {din_s_q[0], port_serial_in};
    clk_prev_d = clk_s_q[1];
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    out_d      = out_q;
    rd_d       = rd_q;
    wr_stb_d   = 1'b0;
    rd_stb_d   = 1'b0;
    if (!active) begin
      cnt_d = '0;
      out_d = '0;
    end else if (rise && cnt_q < 5'(WORD_BITS)) begin
      sh_d  = {sh_q[14:0], din_s_q[1]};
      cnt_d = cnt_q + 5'd1;
      if (cnt_q == 5'd7) begin
        rd_d     = sh_q[6];
        rd_stb_d = sh_q[6];
      end
      if (cnt_q == 5'(WORD_BITS - 1)) wr_stb_d = ~sh_q[14];
    end else if (fall && rd_q && cnt_q >= 5'd8) begin
      out_d = (cnt_q == 5'd8) ? link.rdata : {out_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_s_q    <= 2'h3;
      clk_s_q    <= 2'h0;
      din_s_q    <= 2'h0;
      clk_prev_q <= 1'b0;
      cnt_q      <= 5'h00;
      sh_q       <= 16'h0000;
      out_q      <= 8'h00;
      rd_q       <= 1'b0;
      wr_stb_q   <= 1'b0;
      rd_stb_q   <= 1'b0;
    end else begin
      sel_s_q    <= sel_s_d;
      clk_s_q    <= clk_s_d;
      din_s_q    <= din_s_d;
      clk_prev_q <= clk_prev_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      out_q      <= out_d;
      rd_q       <= rd_d;
      wr_stb_q   <= wr_stb_d;
      rd_stb_q   <= rd_stb_d;
    end
  end

  assign link.wr_stb   = wr_stb_q;
  assign link.rd_stb   = rd_stb_q;
  assign link.index    = rd_stb_q ? sh_q[6:0] : sh_q[14:8];
  assign link.wdata    = sh_q[7:0];
  assign port_serial_out = out_q[7];

  // read data must reach the pin at the first falling edge after bit 8
  sequence ninth_fall_s;
    fall && rd_q && cnt_q == 5'd8;
  endsequence
  read_data_drive_a: assert property (@(posedge core_clk) disable iff (rst)
    ninth_fall_s |=> port_serial_out == $past(link.rdata[7]))
    else $error("read data not driven after eighth clock");
  write_only_full_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_stb_q |-> cnt_q == 5'(WORD_BITS))
    else $error("write strobe before sixteenth clock");
  write_bit_low_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_stb_q |-> !sh_q[15])
    else $error("write strobe with read bit set");
  idle_out_low_a: assert property (@(posedge core_clk) disable iff (rst)
    !active |=> port_serial_out == 1'b0)
    else $error("serial out not idle outside frame");
endmodule
`default_nettype wire

// File: tb/host_port_model.sv
// behavioural host controller for the four-wire control port
// assumes one transfer at a time; the bit clock idles low and stands still between frames
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  output logic     port_select_n,   // frame select, low active
  output logic     port_bit_clock,  // 320 ns bit clock, frames only
  output logic     port_serial_in,  // serial data to device
  input  wire logic port_serial_out // serial data from device
);
  initial begin
    port_select_n  = 1'b1;
    port_bit_clock = 1'b0;
    port_serial_in = 1'b1;
  end

  // nclk below sixteen gives a deliberately short frame
  task automatic xfer(input logic [15:0] word, input int nclk, output logic [7:0] rdata);
    rdata = 8'h00;
    port_select_n = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      port_serial_in = word[15-i];
      #160;
      port_bit_clock = 1'b1;
      if (i >= 8) begin
        rdata[15-i] = port_serial_out;
      end
      #160;
      port_bit_clock = 1'b0;
    end
    #160;
    port_select_n = 1'b1;
    // released line must not keep its last value
    port_serial_in = ~port_serial_in;
    #400;
  endtask
endmodule
`default_nettype wire

// File: tb/test_audio_dac_mode_register_bank.sv
// self-checking bench for the mode-control register bank
// assumes the host model drives the port; flag inputs driven on core_clk
`timescale 1ns/1ps
`default_nettype none
module test_audio_dac_mode_register_bank;
  import dac_mode_pkg::*;
  localparam logic [4:0] TEST_ID = 5'h0B; // arbitrary value
  typedef struct { logic [6:0] idx; logic [7:0] wdata; logic [7:0] exp; } row_t;
  logic       core_clk = 1'b0;
  logic       rst, port_select_n, port_bit_clock, port_serial_in, port_serial_out;
  logic       left_zero_detected, right_zero_detected, atten_load_enable, deemph_enable;
  logic       soft_mute, output_phase_invert, dac_output_disable, zero_pin_function;
  logic       bypass_mono_stereo_select, rolloff_select, infinite_zero_mute_enable;
  logic       soft_system_reset, stream_mode_enable, filter_bypass_enable, mono_enable;
  logic       single_channel_source, pcm_zero_flag_enable, zero_flag_drive_n;
  logic       left_zero_flag_out, right_zero_flag_out;
  logic [7:0] left_atten_level, right_atten_level, d;
  logic [2:0] audio_format_select;
  logic [1:0] deemph_rate_select, fir_performance_select, atten_rate_select;
  logic [1:0] oversample_rate_select, fir_rate_select, stream_zero_flag_control;
  int         err_total  = 0;
  int         num_checks = 0;
  logic [7:0] rst_vals [8] = '{8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00, 8'h01, 8'h00, {3'h0, TEST_ID}};
  row_t       rows [9] = '{'{7'h10, 8'hA5, 8'hA5}, '{7'h11, 8'h3C, 8'h3C}, '{7'h12, 8'hFF, 8'hFF},
                           '{7'h13, 8'hFF, 8'hFF}, '{7'h14, 8'hFF, 8'h7F}, '{7'h15, 8'hFF, 8'h07},
                           '{7'h16, 8'hFF, 8'h02}, '{7'h17, 8'hFF, {3'h0, TEST_ID}},
                           '{7'h09, 8'h5A, 8'h00}};

  audio_dac_mode_register_bank #(.DEVICE_ID(TEST_ID)) audio_dac_mode_register_bank_inst (
    .core_clk, .rst, .port_select_n, .port_bit_clock, .port_serial_in, .port_serial_out,
    .left_zero_detected, .right_zero_detected, .left_atten_level, .right_atten_level,
    .atten_load_enable, .audio_format_select, .deemph_rate_select, .fir_performance_select,
    .deemph_enable, .soft_mute, .output_phase_invert, .atten_rate_select, .dac_output_disable,
    .zero_pin_function, .bypass_mono_stereo_select, .rolloff_select, .infinite_zero_mute_enable,
    .soft_system_reset, .stream_mode_enable, .filter_bypass_enable, .mono_enable,
    .single_channel_source, .oversample_rate_select, .fir_rate_select, .pcm_zero_flag_enable,
    .stream_zero_flag_control, .zero_flag_drive_n, .left_zero_flag_out,
    .right_zero_flag_out);

  host_port_model host_port_model_inst (
    .port_select_n, .port_bit_clock, .port_serial_in, .port_serial_out);

  always #20 core_clk = ~core_clk;

  task automatic rd(input logic [6:0] idx, output logic [7:0] q);
    @(posedge core_clk);
    #1;
    host_port_model_inst.xfer({1'b1, idx, 8'h00}, 16, q);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] v, input int n = 16);
    logic [7:0] unused;
    @(posedge core_clk);
    #1;
    host_port_model_inst.xfer({1'b0, idx, v}, n, unused);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // longest run is about thirty-five frames of six microseconds
  initial begin
    #1_000_000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    left_zero_detected = 1'b0;
    right_zero_detected = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rd(7'h10 + 7'(i), d);
      chk(d, rst_vals[i], "reset value");
    end
    chk({stream_mode_enable, soft_system_reset, filter_bypass_enable, mono_enable,
         single_channel_source, zero_pin_function, infinite_zero_mute_enable,
         pcm_zero_flag_enable}, 8'h01, "reset outputs");
    chk({4'h0, oversample_rate_select, stream_zero_flag_control}, 8'h00, "reset fields");
    chk({5'h00, zero_flag_drive_n, left_zero_flag_out, right_zero_flag_out}, 8'h04,
        "reset pins");
    $display("test reset values done");
    @(posedge core_clk);
    #1 right_zero_detected = 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(rows[i].idx, rows[i].wdata);
      rd(rows[i].idx, d);
      chk(d, rows[i].exp, "readback");
    end
    $display("test register table done");
    // stream mode with every control bit set
    chk(left_atten_level, 8'hA5, "left level");
    chk(right_atten_level, 8'h3C, "right level");
    chk({fir_performance_select, deemph_rate_select, fir_rate_select, oversample_rate_select},
        8'hCC, "stream rate fields");
    chk({rolloff_select, infinite_zero_mute_enable, pcm_zero_flag_enable, soft_system_reset,
         stream_mode_enable, filter_bypass_enable, mono_enable, single_channel_source},
        8'h1F, "stream mode bits");
    chk({1'b0, zero_pin_function, bypass_mono_stereo_select, stream_zero_flag_control,
         zero_flag_drive_n, atten_rate_select}, 8'h7B, "zero pin bits");
    chk({5'h00, zero_flag_drive_n, left_zero_flag_out, right_zero_flag_out}, 8'h01,
        "flag pins");
    chk({atten_load_enable, deemph_enable, soft_mute, output_phase_invert, dac_output_disable,
         audio_format_select}, 8'hFF, "format bits");
    $display("test stream mode done");
    for (int k = 0; k < 3; k++) begin
      wr(7'h14, 8'(k));
      chk({6'h00, oversample_rate_select}, 8'(k), "oversample code");
    end
    chk({fir_performance_select, deemph_rate_select, fir_rate_select, oversample_rate_select},
        8'h32, "pcm rate fields");
    chk({rolloff_select, infinite_zero_mute_enable, pcm_zero_flag_enable, soft_system_reset,
         stream_mode_enable, filter_bypass_enable, mono_enable, single_channel_source},
        8'hE0, "pcm mode bits");
    chk({4'h0, bypass_mono_stereo_select, 1'b0, stream_zero_flag_control}, 8'h00,
        "pcm gated bits");
    wr(7'h14, 8'h10);
    chk({rolloff_select, infinite_zero_mute_enable, pcm_zero_flag_enable,
         bypass_mono_stereo_select, filter_bypass_enable, stream_mode_enable,
         oversample_rate_select}, 8'h78, "bypass mode bits");
    $display("test pcm mode done");
    wr(7'h10, 8'h00, 15);
    rd(7'h10, d);
    chk(d, 8'hA5, "short frame");
    @(posedge core_clk);
    #1 left_zero_detected = 1'b1;
    right_zero_detected = 1'b0;
    rd(7'h16, d);
    chk(d, 8'h01, "left flag");
    $display("test short frame and flags done");
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge core_clk);
    rd(7'h10, d);
    chk(d, 8'hFF, "level after reset");
    rd(7'h14, d);
    chk(d, 8'h00, "mode after reset");
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
